// *** rtl/amp_serial_control_port.sv ***
// i2c slave control port that sets the amplifier control bits
//
// Function
// - B3 selects internal or external gain
// - B2 selects fixed 0dB or adjustable volume
// - B1 mutes; B0 low shuts down
// - select pin low means I2C, high SPI
// - answer address 110110X0, X from pin
// - address MSB first, sampled rising clock
// - matching address acknowledged low ninth pulse
// - eight data bits MSB first
// - every data byte acknowledged low
// - further bytes accepted in turn
// - top bits 000 mode, 100 volume
// - bridged only when sense and B4 low
// - beep reaches bridged output always
`include "amp_ctrl_regs.svh"

module amp_serial_control_port (
  // clock, enable and reset
  input wire logic clock,
  input wire logic clockEnable,
  input wire logic rst_n,
  // i2c bus pins
  input wire logic sclIn,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  // straps and sense pins
  input wire logic interfaceSelectPin,
  input wire logic address_select_pin,
  input wire logic headphone_detect_pin,
  input wire logic beepDetect,
  // control outputs
  output logic headphone_force_bit,
  output logic externalGain,
  output logic adjustableVolume,
  output logic muteOn,
  output logic deviceActive,
  output logic [4:0] volumeCode,
  output logic bridged_output,
  output logic single_ended_output,
  output logic audioToBridged,
  output logic i2cSelected
);

  ////////////////////////////////////////////////////////////////////////////
  // input synchronisers
  logic [1:0] sclSync; // scl two-stage synchroniser
  logic [1:0] sdaSync; // sda two-stage synchroniser
  logic [1:0] selSync; // interface select synchroniser
  logic [1:0] idSync; // address select synchroniser
  logic [1:0] hpSync; // headphone sense synchroniser
  logic [1:0] beepSync; // beep detect synchroniser
  logic sclPrev; // previous synchronised scl
  logic sdaPrev; // previous synchronised sda

  // all pins pass two flops before use
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      sclSync <= 2'h3;
      sdaSync <= 2'h3;
      selSync <= 2'h0;
      idSync <= 2'h0;
      hpSync <= 2'h0;
      beepSync <= 2'h0;
      sclPrev <= 1'b1;
      sdaPrev <= 1'b1;
    end else if (clockEnable) begin
      sclSync <= {sclSync[0], sclIn};
      sdaSync <= {sdaSync[0], sdaIn};
      selSync <= {selSync[0], interfaceSelectPin};
      idSync <= {idSync[0], address_select_pin};
      hpSync <= {hpSync[0], headphone_detect_pin};
      beepSync <= {beepSync[0], beepDetect};
      sclPrev <= sclSync[1];
      sdaPrev <= sdaSync[1];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // bus event decode
  wire scl = sclSync[1]; // settled clock level
  wire sda = sdaSync[1]; // settled data level
  wire sclRise = scl && !sclPrev; // rising clock edge
  wire sclFall = !scl && sclPrev; // falling clock edge
  wire i2cMode = !selSync[1];
  wire startSeen = i2cMode && scl && sclPrev && sdaPrev && !sda; // start
  wire stopSeen = scl && sclPrev && !sdaPrev && sda; // stop

  ////////////////////////////////////////////////////////////////////////////
  // shift state
  amp_ctrl_pkg::slave_state_t state; // protocol state
  amp_ctrl_pkg::slave_state_t next_state; // next protocol state
  logic [7:0] shiftReg; // received bits
  logic [2:0] bitCount; // bits seen in byte
  logic [4:0] modeBits; // B4..B0 held
  logic [4:0] volume; // volume code held

  wire [7:0] next_shift = {shiftReg[6:0], sda};
  wire lastBit = (bitCount == 3'h7); // eighth bit
  wire [7:0] ownAddress = {`ADDR_UPPER, idSync[1], 1'b0};
  wire addrMatch = (next_shift == ownAddress);
  wire isMode = (next_shift[7:5] == `DATA_SEL_MODE);
  wire isVolume = (next_shift[7:5] == `DATA_SEL_VOLUME);
  wire byteDone = sclRise && lastBit; // whole byte in

  // next state on clock edges
  always_comb begin
    next_state = state;
    unique case (state)
      amp_ctrl_pkg::IDLE: begin
        next_state = amp_ctrl_pkg::IDLE;
      end
      amp_ctrl_pkg::ADDR: begin
        if (byteDone) begin
          // mismatch drops to ignore
          next_state = addrMatch ? amp_ctrl_pkg::ADDR_ACK
                                 : amp_ctrl_pkg::IGNORE;
        end
      end
      amp_ctrl_pkg::ADDR_ACK, amp_ctrl_pkg::DATA_ACK: begin
        // ack held until falling edge of ninth pulse
        if (sclFall && bitCount == 3'h1) begin
          next_state = amp_ctrl_pkg::DATA;
        end
      end
      amp_ctrl_pkg::DATA: begin
        if (byteDone) begin
          next_state = amp_ctrl_pkg::DATA_ACK;
        end
      end
      amp_ctrl_pkg::IGNORE: begin
        next_state = amp_ctrl_pkg::IGNORE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // protocol sequencer
  // bitCount in ack states counts the ack pulse: 0 before, 1 after rise
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      state <= amp_ctrl_pkg::IDLE;
      shiftReg <= 8'h00;
      bitCount <= 3'h0;
    end else if (clockEnable) begin
      if (startSeen) begin
        state <= amp_ctrl_pkg::ADDR; // start restarts
        bitCount <= 3'h0;
      end else if (stopSeen || !i2cMode) begin
        state <= amp_ctrl_pkg::IDLE;
        bitCount <= 3'h0;
      end else begin
        state <= next_state;
        if (sclRise) begin
          shiftReg <= next_shift;
          bitCount <= (state == amp_ctrl_pkg::ADDR_ACK ||
                       state == amp_ctrl_pkg::DATA_ACK) ? 3'h1
                      : (lastBit ? 3'h0 : bitCount + 3'h1);
        end else if (sclFall && next_state == amp_ctrl_pkg::DATA &&
                     state != amp_ctrl_pkg::DATA) begin
          bitCount <= 3'h0;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // acknowledge drive
  // pull low from the fall after bit eight until the ninth pulse falls
  wire ackState = (state == amp_ctrl_pkg::ADDR_ACK ||
                   state == amp_ctrl_pkg::DATA_ACK);
  wire next_ackDrive = ackState && !(sclFall && bitCount == 3'h1)
                       && !stopSeen && !startSeen;
  logic ackDrive; // staged ack drive
  wire ackArmed = ackDrive || (ackState && sclFall && bitCount == 3'h0);

  // ack begins after the falling edge ending bit eight
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      ackDrive <= 1'b0;
      sdaOut <= 1'b1;
      sdaOe <= 1'b0;
    end else if (clockEnable) begin
      ackDrive <= next_ackDrive && ackArmed;
      sdaOut <= 1'b0;
      sdaOe <= next_ackDrive && ackArmed;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control bits and output stage
  wire loadMode = byteDone && state == amp_ctrl_pkg::DATA && isMode;
  wire loadVolume = byteDone && state == amp_ctrl_pkg::DATA && isVolume;
  wire bridgedSel = !hpSync[1] && !modeBits[4];

  // data bytes update their registers, outputs follow
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      modeBits <= `MODE_RESET;
      volume <= `VOLUME_RESET;
      headphone_force_bit <= 1'b0;
      externalGain <= 1'b0;
      adjustableVolume <= 1'b0;
      muteOn <= 1'b0;
      deviceActive <= 1'b0;
      volumeCode <= 5'h00;
      bridged_output <= 1'b1;
      single_ended_output <= 1'b0;
      audioToBridged <= 1'b0;
      i2cSelected <= 1'b1;
    end else if (clockEnable) begin
      if (loadMode) begin
        modeBits <= next_shift[4:0];
      end
      if (loadVolume) begin
        volume <= next_shift[4:0];
      end
      headphone_force_bit <= modeBits[4];
      externalGain <= modeBits[3];
      adjustableVolume <= modeBits[2];
      muteOn <= modeBits[1];
      deviceActive <= modeBits[0];
      volumeCode <= volume;
      bridged_output <= bridgedSel;
      single_ended_output <= !bridgedSel;
      // beep forces bridged path regardless of mute/headphone
      audioToBridged <= beepSync[1] ||
                        (bridgedSel && !modeBits[1]);
      i2cSelected <= i2cMode;
    end
  end

endmodule : amp_serial_control_port

// *** rtl/amp_ctrl_regs.svh ***
// constants for the amplifier serial control port
`ifndef AMP_CTRL_REGS_SVH
`define AMP_CTRL_REGS_SVH
`define ADDR_UPPER 6'h36
`define DATA_SEL_MODE 3'h0
`define DATA_SEL_VOLUME 3'h4
`define MODE_RESET 5'h00
`define VOLUME_RESET 5'h00
`define MAX_SCL_KHZ 400
`endif

// *** rtl/amp_ctrl_pkg.sv ***
// types for the amplifier serial control port
package amp_ctrl_pkg;
  typedef enum logic [2:0] {
    IDLE = 3'b000,
    ADDR = 3'b001,
    ADDR_ACK = 3'b010,
    DATA = 3'b011,
    DATA_ACK = 3'b100,
    IGNORE = 3'b101
  } slave_state_t;
endpackage : amp_ctrl_pkg

// *** tb/amp_serial_control_port_checker.sv ***
// assertions on the amplifier control port pins
module amp_serial_control_port_checker (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // bus pins
  input wire logic sclIn,
  input wire logic sdaOut,
  input wire logic sdaOe,
  // straps and outputs
  input wire logic interfaceSelectPin,
  input wire logic beepDetect,
  input wire logic bridged_output,
  input wire logic single_ended_output,
  input wire logic audioToBridged,
  input wire logic i2cSelected
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////////////
  // ack drive moves only while the bus clock is low
  chk_ack_rise: assert property ($rose(sdaOe) |-> !sclIn)
    else $error("ack edge with clock high");
  chk_ack_hold: assert property ($rose(sclIn) && sdaOe |-> sdaOe[*6])
    else $error("ack dropped in pulse");
  chk_ack_low: assert property (sdaOe |-> !sdaOut)
    else $error("ack drives high");
  chk_spi_quiet: assert property (!i2cSelected |-> !sdaOe)
    else $error("ack in spi mode");
  // strap and output stage relations
  chk_sel_spi: assert property (interfaceSelectPin[*5] |-> !i2cSelected)
    else $error("spi strap ignored");
  chk_sel_i2c: assert property ((!interfaceSelectPin)[*5] |-> i2cSelected)
    else $error("i2c strap ignored");
  chk_stage_split: assert property (bridged_output ^ single_ended_output)
    else $error("stages not complementary");
  chk_beep_pass: assert property (beepDetect[*5] |-> audioToBridged)
    else $error("beep blocked");
  cover property ($rose(sdaOe));
  cover property ($rose(single_ended_output));
  cover property (beepDetect && audioToBridged);
endmodule : amp_serial_control_port_checker

// *** tb/i2c_master_model.sv ***
// bus master model for the two-wire control bus
module i2c_master_model (
  // bus lines
  output logic scl,
  output logic sdaDrive,
  input wire logic sda
);
  timeunit 1ns;
  timeprecision 1ps;
  // idle high, clock stands still between frames
  initial begin
    scl = 1'h1;
    sdaDrive = 1'h1;
  end
  // data falls while clock high
  task automatic start();
    #40 sdaDrive = 1'h0;
    #40 scl = 1'h0;
  endtask : start
  // eight bits msb first, 80 ns clock, then sample the answer
  task automatic sendByte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      #20 sdaDrive = b[i];
      #20 scl = 1'h1;
      #40 scl = 1'h0;
    end
    #20 sdaDrive = 1'h1;
    #40 scl = 1'h1;
    #20 ack = !sda;
    #20 scl = 1'h0;
    #60;
  endtask : sendByte
  // data rises while clock high
  task automatic stop();
    #20 sdaDrive = 1'h0;
    #20 scl = 1'h1;
    #40 sdaDrive = 1'h1;
    #80;
  endtask : stop
endmodule : i2c_master_model

// *** tb/amp_serial_control_port_tb_top.sv ***
// self-checking bench for the amplifier control port
module amp_serial_control_port_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  // stimulus, bus lines and results
  logic clock = 1'h0, rst_n = 1'h0, selPin = 1'h0, addrPin = 1'h0;
  logic beep = 1'h0, hpPin = 1'h0, scl, sdaDrive, sdaOut, sdaOe, ack;
  logic hpForce, extGain, adjVol, mute, active, bridged, single, toBr;
  logic i2cSel;
  logic [4:0] volume;
  int fails = 0, num_checks = 0;
  // pulled-up wire, low while either side pulls
  wire logic sda = (sdaOe ? sdaOut : 1'h1) & sdaDrive;
  wire logic [7:0] mode = {3'h0, hpForce, extGain, adjVol, mute, active};
  always #5 clock = ~clock;
  amp_serial_control_port amp_serial_control_port_inst (
    .clock, .clockEnable(1'h1), .rst_n, .sclIn(scl), .sdaIn(sda), .sdaOut,
    .sdaOe, .interfaceSelectPin(selPin), .address_select_pin(addrPin),
    .headphone_detect_pin(hpPin), .beepDetect(beep),
    .headphone_force_bit(hpForce), .externalGain(extGain),
    .adjustableVolume(adjVol), .muteOn(mute), .deviceActive(active),
    .volumeCode(volume), .bridged_output(bridged),
    .single_ended_output(single), .audioToBridged(toBr),
    .i2cSelected(i2cSel));
  i2c_master_model i2c_master_model_inst (.scl, .sdaDrive, .sda);
  // compare one value, count and report
  task automatic expect8(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask : expect8
  // step just past a clock edge
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : tick
  // send one byte and compare its answer
  task automatic wr(input logic [7:0] b, input logic expAck);
    i2c_master_model_inst.sendByte(b, ack);
    expect8({7'h00, ack}, {7'h00, expAck});
  endtask : wr
  // print counts and verdict, end the run
  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : test_done
  ////////////////////////////////////////////////////////////////////
  // watchdog cuts a hang short
  initial begin
    #100us;
    fails++;
    test_done();
  end
  // main sequence
  initial begin
    tick(4);
    rst_n = 1'h1;
    tick(4);
    expect8({mode[4:0], bridged, i2cSel, 1'h0}, 8'h06);
    i2c_master_model_inst.start();
    wr(8'hD8, 1'h1);
    wr(8'h0F, 1'h1);
    expect8(mode, 8'h0F);
    wr(8'h95, 1'h1);
    wr(8'h3F, 1'h1);
    expect8({volume, 3'h0}, 8'hA8);
    expect8(mode, 8'h0F);
    i2c_master_model_inst.stop();
    beep = 1'h1;
    tick(6);
    expect8({7'h00, toBr}, 8'h01);
    beep = 1'h0;
    tick(6);
    expect8({7'h00, toBr}, 8'h00);
    // headphone plugged in forces the single-ended stage
    hpPin = 1'h1;
    tick(6);
    expect8({6'h00, bridged, single}, 8'h01);
    hpPin = 1'h0;
    $display("write test done");
    addrPin = 1'h1;
    tick(6);
    i2c_master_model_inst.start();
    wr(8'hD8, 1'h0);
    wr(8'h10, 1'h0);
    i2c_master_model_inst.stop();
    expect8(mode, 8'h0F);
    i2c_master_model_inst.start();
    wr(8'hDA, 1'h1);
    wr(8'h10, 1'h1);
    i2c_master_model_inst.stop();
    beep = 1'h1;
    tick(6);
    expect8({mode[4:0], bridged, single, toBr}, 8'h83);
    $display("address test done");
    selPin = 1'h1;
    tick(6);
    i2c_master_model_inst.start();
    wr(8'hDA, 1'h0);
    i2c_master_model_inst.stop();
    expect8({7'h00, i2cSel}, 8'h00);
    $display("select test done");
    test_done();
  end
endmodule : amp_serial_control_port_tb_top
// checker beside the design's own ports
bind amp_serial_control_port amp_serial_control_port_checker
  amp_serial_control_port_checker_inst (.clock, .rst_n, .sclIn, .sdaOut,
  .sdaOe, .interfaceSelectPin, .beepDetect, .bridged_output,
  .single_ended_output, .audioToBridged, .i2cSelected);
